//--- hdl/omf_manual_frame.sv
// Purpose: Manual-mode frame composer for an octal or serial SPI flash.
// Assumes: APB slave with zero wait states, pins sampled on clock.
// Notes:   Pin outputs are registered, so they trail the shifter by one
//          clock; the serial clock half period is two clocks.
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module omf_manual_frame (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        rst_n,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Flash pins.
  output logic             chip_select_n,
  output logic             flash_clock,
  input  wire logic [7:0]  flash_data_line_i,
  output logic      [7:0]  flash_data_line_o,
  output logic      [7:0]  flash_data_line_oe,
  // Status.
  output logic             busy
);

  // Registers.
  logic [31:0] cmd_q;
  logic [31:0] en_q;
  logic [31:0] ddr_q;
  logic [31:0] opt_q;
  logic [31:0] addr_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic [4:0]  dummy_q;
  logic [13:0] lvl_q;
  logic [5:0]  ctrl_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  // Frame engine.
  omf_pkg::omf_phase_t phase_q;
  omf_pkg::omf_phase_t load_phase;
  logic        cs_n_q;
  logic        sck_q;
  logic [1:0]  div_q;
  logic [31:0] sh_q;
  logic [31:0] rx_q;
  logic [5:0]  units_q;
  logic        w8_q;
  logic        ddr_f_q;
  logic        drive_q;
  logic [7:0]  io_out_q;
  logic [7:0]  io_oe_q;
  logic [7:0]  pin_val;
  logic [7:0]  pin_oe;
  logic [31:0] ld_word;
  logic [5:0]  ld_bits;
  logic [5:0]  ld_units;
  logic        ld_w8;
  logic        ld_ddr;
  logic        ld_drive;
  logic [2:0]  opt_n;
  logic [31:0] rd_mux;

  // One or eight lines from a two-bit width code.
  function automatic logic is_octal(input logic [1:0] w);
    return w == omf_pkg::WIDTH_EIGHT;
  endfunction

  // Line level from a two-bit setting, returned as {enable, value}.
  function automatic logic [1:0] line_level(input logic [1:0] sel,
                                            input logic       last_v,
                                            input logic       last_oe);
    logic [1:0] r;
    r = 2'h0;
    unique case (sel)
      omf_pkg::LVL_ZERO: r = 2'h2;
      omf_pkg::LVL_ONE:  r = 2'h3;
      omf_pkg::LVL_PREV: r = {last_oe, last_v & last_oe};
      omf_pkg::LVL_HIZ:  r = 2'h0;
    endcase
    return r;
  endfunction

  // First enabled phase at or after a position; PH_NONE when none left.
  function automatic logic [2:0] pick_phase(input logic [5:0] mask,
                                            input logic [2:0] from);
    logic [2:0] r;
    r = omf_pkg::PH_NONE;
    for (int i = 5; i >= 0; i--) begin
      if (mask[i] && (3'(i) >= from)) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // APB decode; the slave never inserts wait states.
  wire        setup    = psel && !penable;
  wire        wr_en    = psel && penable && pwrite;
  wire        active   = (phase_q != omf_pkg::OMF_IDLE);
  wire        cfg_wr   = wr_en && !active;
  wire        wr_cmd   = cfg_wr && (paddr == omf_pkg::OFS_CMD);
  wire        wr_en_r  = cfg_wr && (paddr == omf_pkg::OFS_ENABLE);
  wire        wr_ddr   = cfg_wr && (paddr == omf_pkg::OFS_DDR);
  wire        wr_opt   = cfg_wr && (paddr == omf_pkg::OFS_OPT);
  wire        wr_dummy = cfg_wr && (paddr == omf_pkg::OFS_DUMMY);
  wire        wr_addr  = cfg_wr && (paddr == omf_pkg::OFS_ADDR);
  wire        wr_lvl   = cfg_wr && (paddr == omf_pkg::OFS_LEVEL);
  wire        wr_ctrl  = cfg_wr && (paddr == omf_pkg::OFS_CTRL);
  wire        wr_wdata = cfg_wr && (paddr == omf_pkg::OFS_WDATA);
  wire        hit      = (paddr <= omf_pkg::OFS_STATUS) &&
                         (paddr[1:0] == 2'h0);
  // The start write brings its own data settings to the same edge, so a
  // data-only frame can start; writes are blocked while a frame runs.
  wire [5:0]  ctrl_now = wr_ctrl ? (pwdata[5:0] & omf_pkg::CTRL_MASK) :
                         ctrl_q;

  // Phase selection from the enable fields.
  wire [3:0]  addr_sel = en_q[omf_pkg::EN_ADDR_SEL +: 4];
  wire        addr_on  = (addr_sel == omf_pkg::ADDR_24) ||
                         (addr_sel == omf_pkg::ADDR_32) ||
                         (addr_sel == omf_pkg::ADDR_OCTAL); // RULE_08
  wire [5:0]  en_mask  = {ctrl_now[omf_pkg::CTRL_DATA_ON],
                          en_q[omf_pkg::EN_DUMMY_ON],
                          opt_n != 3'h0,
                          addr_on,
                          en_q[omf_pkg::EN_OCMD_ON],  // RULE_06
                          en_q[omf_pkg::EN_CMD_ON]};  // RULE_03
  wire        start_go = wr_ctrl && pwdata[omf_pkg::CTRL_START] &&
                         (en_mask != 6'h0);
  wire [2:0]  cur_idx  = phase_q;
  wire [2:0]  first_idx = pick_phase(en_mask, 3'h0);
  wire [2:0]  next_idx = pick_phase(en_mask, cur_idx + 3'h1); // RULE_22
  wire [2:0]  load_idx = start_go ? first_idx : next_idx;
  wire        rd_frame = ctrl_now[omf_pkg::CTRL_READ];
  wire [1:0]  nbytes_m1 = ctrl_now[omf_pkg::CTRL_BYTES +: 2];
  wire [4:0]  wd_shift = {2'h3 - nbytes_m1, 3'h0};
  // Out-of-range dummy counts are held to the supported span.
  wire [4:0]  dummy_cyc = (dummy_q < omf_pkg::DUMMY_MIN) ?
                          omf_pkg::DUMMY_MIN :
                          (dummy_q > omf_pkg::DUMMY_MAX) ?
                          omf_pkg::DUMMY_MAX : dummy_q; // RULE_15

  assign load_phase = (load_idx == omf_pkg::PH_NONE) ? omf_pkg::OMF_END :
                      omf_pkg::omf_phase_t'(load_idx);

  // Option byte count; byte three always leads.
  always_comb begin
    unique case (en_q[omf_pkg::EN_OPT_SEL +: 4])
      omf_pkg::OPT_B3:   opt_n = 3'h1; // RULE_11
      omf_pkg::OPT_B32:  opt_n = 3'h2;
      omf_pkg::OPT_B321: opt_n = 3'h3;
      omf_pkg::OPT_ALL:  opt_n = 3'h4;
      default:           opt_n = 3'h0;
    endcase
  end

  // Shift word, length, width and rate of the phase about to start.
  always_comb begin
    ld_word  = 32'h0;
    ld_bits  = omf_pkg::BITS_BYTE;
    ld_w8    = 1'b0;
    ld_ddr   = 1'b0;
    ld_drive = 1'b1;
    unique case (load_phase)
      omf_pkg::OMF_CMD: begin
        ld_word = {cmd_q[omf_pkg::CMD_LSB +: 8], 24'h0}; // RULE_01
        ld_w8   = is_octal(en_q[omf_pkg::EN_CMD_W +: 2]); // RULE_02
      end
      omf_pkg::OMF_OCMD: begin
        ld_word = {cmd_q[omf_pkg::OCMD_LSB +: 8], 24'h0}; // RULE_04
        ld_w8   = is_octal(en_q[omf_pkg::EN_OCMD_W +: 2]); // RULE_05
      end
      omf_pkg::OMF_ADDR: begin
        ld_word = (addr_sel == omf_pkg::ADDR_24) ?
                  {addr_q[23:0], 8'h0} : addr_q; // RULE_08
        ld_bits = (addr_sel == omf_pkg::ADDR_24) ?
                  omf_pkg::BITS_24 : omf_pkg::BITS_32;
        ld_w8   = is_octal(en_q[omf_pkg::EN_ADDR_W +: 2]); // RULE_07
        ld_ddr  = ddr_q[omf_pkg::DDR_ADDR]; // RULE_09
      end
      omf_pkg::OMF_OPT: begin
        ld_word = opt_q; // RULE_13
        ld_bits = {opt_n, 3'h0};
        ld_w8   = is_octal(en_q[omf_pkg::EN_OPT_W +: 2]); // RULE_10
        ld_ddr  = ddr_q[omf_pkg::DDR_OPT]; // RULE_12
      end
      omf_pkg::OMF_DUMMY: begin
        ld_bits  = {1'b0, dummy_cyc}; // RULE_14
        ld_drive = 1'b0;
      end
      omf_pkg::OMF_DATA: begin
        ld_word  = wdata_q << wd_shift;
        ld_bits  = {3'(nbytes_m1) + 3'h1, 3'h0};
        ld_w8    = is_octal(en_q[omf_pkg::EN_DATA_W +: 2]); // RULE_16
        ld_ddr   = ddr_q[omf_pkg::DDR_DATA]; // RULE_17
        ld_drive = !rd_frame;
      end
      default: begin
        ld_drive = 1'b0;
      end
    endcase
  end
  assign ld_units = ld_w8 ? {3'h0, ld_bits[5:3]} : ld_bits;

  // Serial clock timing: SDR moves on the falling edge, DDR on both.
  wire        tick    = active && (div_q == 2'(omf_pkg::HALF_CYC - 1));
  wire        in_end  = (phase_q == omf_pkg::OMF_END);
  wire        advance = tick && !in_end && (ddr_f_q || sck_q);
  wire        sample  = tick && (phase_q == omf_pkg::OMF_DATA) &&
                        !drive_q && (ddr_f_q || !sck_q);
  wire [31:0] sh_next = w8_q ? {sh_q[23:0], 8'h0} : {sh_q[30:0], 1'b0};

  // Half-period divider; restarts with every frame.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 2'h0;
    end else if (!active || tick) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end

  // Frame sequencer: select, phases in order, then release.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= omf_pkg::OMF_IDLE;
      cs_n_q  <= 1'b1;
      sck_q   <= 1'b0;
      sh_q    <= 32'h0;
      units_q <= 6'h0;
      w8_q    <= 1'b0;
      ddr_f_q <= 1'b0;
      drive_q <= 1'b0;
    end else if (start_go) begin
      cs_n_q  <= 1'b0; // RULE_23
      sck_q   <= 1'b0;
      phase_q <= load_phase;
      sh_q    <= ld_word;
      units_q <= ld_units;
      w8_q    <= ld_w8;
      ddr_f_q <= ld_ddr;
      drive_q <= ld_drive;
    end else if (tick && in_end) begin
      cs_n_q  <= 1'b1; // RULE_23
      sck_q   <= 1'b0;
      phase_q <= omf_pkg::OMF_IDLE;
    end else if (tick) begin
      sck_q <= !sck_q;
      if (advance && (units_q == 6'h1)) begin
        phase_q <= load_phase; // RULE_22
        sh_q    <= ld_word;
        units_q <= ld_units;
        w8_q    <= ld_w8;
        ddr_f_q <= ld_ddr;
        drive_q <= ld_drive;
      end else if (advance) begin
        sh_q    <= sh_next;
        units_q <= units_q - 6'h1;
      end
    end
  end

  // Read data shifts in from line one, or all eight lines.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_q <= 32'h0;
    end else if (start_go) begin
      rx_q <= 32'h0;
    end else if (sample) begin
      rx_q <= w8_q ? {rx_q[23:0], flash_data_line_i} :
                     {rx_q[30:0], flash_data_line_i[1]};
    end
  end

  // Pin levels: idle settings, octal lanes, or one-line fixed levels.
  always_comb begin
    pin_val = 8'h0;
    pin_oe  = 8'h0;
    if (cs_n_q) begin
      for (int i = 0; i < 4; i++) begin
        {pin_oe[i], pin_val[i]} = line_level(lvl_q[2*i +: 2],
                                             io_out_q[i],
                                             io_oe_q[i]); // RULE_18
      end
    end else if (in_end) begin
      pin_val = io_out_q;
      pin_oe  = io_oe_q;
    end else if (w8_q) begin
      pin_val = sh_q[31:24];
      pin_oe  = {8{drive_q}};
    end else begin
      if (drive_q) begin
        {pin_oe[0], pin_val[0]} = {1'b1, sh_q[31]};
      end else begin
        {pin_oe[0], pin_val[0]} = line_level(lvl_q[omf_pkg::LVL_RD0 +: 2],
                                             io_out_q[0],
                                             io_oe_q[0]); // RULE_20
      end
      {pin_oe[2], pin_val[2]} = line_level(lvl_q[omf_pkg::LVL_L2 +: 2],
                                           io_out_q[2],
                                           io_oe_q[2]); // RULE_19
      {pin_oe[3], pin_val[3]} = line_level(lvl_q[omf_pkg::LVL_L3 +: 2],
                                           io_out_q[3],
                                           io_oe_q[3]); // RULE_19
    end
  end

  // Pin registers; their own value is what the keep-last setting holds.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      io_out_q <= 8'h0;
      io_oe_q  <= 8'h0;
    end else begin
      io_out_q <= pin_val;
      io_oe_q  <= pin_oe;
    end
  end

  // Configuration writes; ignored during a frame so it cannot tear.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q   <= 32'h0;
      en_q    <= omf_pkg::RST_ENABLE;
      ddr_q   <= 32'h0;
      opt_q   <= 32'h0;
      dummy_q <= omf_pkg::RST_DUMMY;
      addr_q  <= 32'h0;
      lvl_q   <= omf_pkg::RST_LEVEL;
      ctrl_q  <= 6'h0;
      wdata_q <= 32'h0;
    end else begin
      if (wr_cmd) cmd_q <= pwdata;
      if (wr_en_r) en_q <= pwdata;
      if (wr_ddr) ddr_q <= pwdata;
      if (wr_opt) opt_q <= pwdata; // RULE_13
      if (wr_dummy) dummy_q <= pwdata[4:0];
      if (wr_addr) addr_q <= pwdata;
      if (wr_lvl) lvl_q <= pwdata[13:0];
      if (wr_ctrl) ctrl_q <= pwdata[5:0] & omf_pkg::CTRL_MASK;
      if (wr_wdata) wdata_q <= pwdata;
    end
  end

  // Received word is published when the frame ends.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0;
    end else if (tick && in_end && rd_frame) begin
      rdata_q <= rx_q;
    end
  end

  // Read mux; unmapped offsets read zero and flag an error.
  always_comb begin
    unique case (paddr)
      omf_pkg::OFS_CMD:    rd_mux = cmd_q;
      omf_pkg::OFS_ENABLE: rd_mux = en_q;
      omf_pkg::OFS_DDR:    rd_mux = ddr_q;
      omf_pkg::OFS_OPT:    rd_mux = opt_q;
      omf_pkg::OFS_DUMMY:  rd_mux = {27'h0, dummy_q};
      omf_pkg::OFS_ADDR:   rd_mux = addr_q;
      omf_pkg::OFS_LEVEL:  rd_mux = {18'h0, lvl_q};
      omf_pkg::OFS_CTRL:   rd_mux = {26'h0, ctrl_q};
      omf_pkg::OFS_WDATA:  rd_mux = wdata_q;
      omf_pkg::OFS_RDATA:  rd_mux = rdata_q;
      omf_pkg::OFS_STATUS: rd_mux = {31'h0, active};
      default:             rd_mux = 32'h0;
    endcase
  end

  // Read data and error are captured in the setup cycle.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q  <= 32'h0;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q  <= pwrite ? 32'h0 : rd_mux;
      pslverr_q <= !hit;
    end
  end

  assign prdata             = prdata_q;
  assign pslverr            = pslverr_q;
  assign pready             = 1'b1;
  assign chip_select_n      = cs_n_q;
  assign flash_clock        = sck_q;
  assign flash_data_line_o  = io_out_q;
  assign flash_data_line_oe = io_oe_q;
  assign busy               = active;

  // Checks on the frame and pin behaviour.
  default clocking omf_cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence omf_start_s;
    start_go;
  endsequence

  sequence omf_phase_entry_s;
    $changed(phase_q) && active && $past(active);
  endsequence

  AST_IDLE_DESELECT: assert property ( // RULE_23
    !active |-> chip_select_n)
    else $error("Chip select asserted while no frame runs.");
  AST_CMD_LEADS: assert property ( // RULE_01
    omf_start_s and en_q[omf_pkg::EN_CMD_ON] |=>
    (phase_q == omf_pkg::OMF_CMD) && !chip_select_n &&
    (sh_q[31:24] == $past(cmd_q[7:0])))
    else $error("Frame did not open with the command byte.");
  AST_CMD_SKIPPED: assert property ( // RULE_03
    omf_start_s and !en_q[omf_pkg::EN_CMD_ON] |=>
    phase_q != omf_pkg::OMF_CMD)
    else $error("Disabled command phase was sent.");
  AST_OCMD_SKIPPED: assert property ( // RULE_06
    active && !en_q[omf_pkg::EN_OCMD_ON] |->
    phase_q != omf_pkg::OMF_OCMD)
    else $error("Disabled second command phase was sent.");
  AST_PHASE_ORDER: assert property ( // RULE_22
    omf_phase_entry_s and (phase_q != omf_pkg::OMF_END) |->
    cur_idx > $past(cur_idx))
    else $error("Phases left their fixed order.");
  AST_OPT_HIGH_FIRST: assert property ( // RULE_11
    omf_phase_entry_s and (phase_q == omf_pkg::OMF_OPT) |->
    (sh_q == opt_q) && (units_q == (w8_q ? {3'h0, opt_n} :
                                           {opt_n, 3'h0})))
    else $error("Option bytes did not start with byte three.");
  AST_DUMMY_LEN: assert property ( // RULE_15
    omf_phase_entry_s and (phase_q == omf_pkg::OMF_DUMMY) |->
    (units_q >= 6'h02) && (units_q <= 6'h14) && !drive_q)
    else $error("Dummy length outside two to twenty cycles.");
  AST_OCTAL_DRIVE: assert property ( // RULE_02
    !cs_n_q && !in_end && w8_q && drive_q |=>
    (flash_data_line_oe == 8'hff) &&
    (flash_data_line_o == $past(sh_q[31:24])))
    else $error("Eight-line phase did not drive all lines.");
  AST_SDR_HOLD: assert property ( // RULE_17
    tick && !ddr_f_q && !sck_q && !in_end |=> $stable(sh_q))
    else $error("Single-rate phase shifted on a rising edge.");
  AST_IDLE_HIZ: assert property ( // RULE_18
    cs_n_q && (lvl_q[1:0] == omf_pkg::LVL_HIZ) |=>
    !flash_data_line_oe[0])
    else $error("Line zero driven while idle level is Hi-Z.");
  AST_READ_LINE0: assert property ( // RULE_20
    !cs_n_q && (phase_q == omf_pkg::OMF_DATA) && !w8_q && !drive_q &&
    (lvl_q[omf_pkg::LVL_RD0 +: 2] == omf_pkg::LVL_ZERO) |=>
    flash_data_line_oe[0] && !flash_data_line_o[0])
    else $error("Line zero ignored its one-line read level.");
  AST_LINE2_FIXED: assert property ( // RULE_19
    !cs_n_q && !in_end && !w8_q &&
    (lvl_q[omf_pkg::LVL_L2 +: 2] == omf_pkg::LVL_ONE) |=>
    flash_data_line_oe[2] && flash_data_line_o[2])
    else $error("Line two ignored its one-line fixed level.");

endmodule
`default_nettype wire

//--- pkg/omf_pkg.sv
// Purpose: Constants and types for the manual SPI frame composer.
// Assumes: 40 MHz system clock, APB register access, 32-bit data.
// Notes:   Lane widths use two-bit codes; other codes mean one line.
// How it works
// RULE_01 - Programmable eight-bit command opens the frame
// RULE_02 - Command goes over one or eight lines
// RULE_03 - Command phase only when its enable set
// RULE_04 - Optional second command byte follows the command
// RULE_05 - Second command width one or eight lines
// RULE_06 - Second command only when its enable set
// RULE_07 - Address goes over one or eight lines
// RULE_08 - Address select: none, 24, 32, octal
// RULE_09 - Address at single or double data rate
// RULE_10 - Option bytes over one or eight lines
// RULE_11 - One to four option bytes, highest first
// RULE_12 - Option bytes at single or double rate
// RULE_13 - Four programmable option bytes are held
// RULE_14 - Dummy cycles only when their enable set
// RULE_15 - Dummy count programmable, two to twenty cycles
// RULE_16 - Data phase over one or eight lines
// RULE_17 - Data phase at single or double rate
// RULE_18 - Idle levels per line zero to three
// RULE_19 - Lines two, three fixed in one-line transfers
// RULE_20 - Line zero level during one-line reads
// RULE_21 - Software sets line zero Hi-Z for octal reads
// RULE_22 - Phases go out in fixed order
// RULE_23 - Select wraps all phases, then idle levels
`default_nettype none
package omf_pkg;
  // Timing: serial clock derived from the system clock.
  localparam int unsigned CLK_HZ    = 40_000_000;
  localparam int unsigned SCK_HZ    = 10_000_000;
  localparam int unsigned HALF_CYC  = CLK_HZ / (2 * SCK_HZ);
  // Register byte offsets.
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_ENABLE = 8'h04;
  localparam logic [7:0] OFS_DDR    = 8'h08;
  localparam logic [7:0] OFS_OPT    = 8'h0c;
  localparam logic [7:0] OFS_DUMMY  = 8'h10;
  localparam logic [7:0] OFS_ADDR   = 8'h14;
  localparam logic [7:0] OFS_LEVEL  = 8'h18;
  localparam logic [7:0] OFS_CTRL   = 8'h1c;
  localparam logic [7:0] OFS_WDATA  = 8'h20;
  localparam logic [7:0] OFS_RDATA  = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  // Field positions.
  localparam int CMD_LSB = 0;
  localparam int OCMD_LSB = 16;
  localparam int EN_CMD_W = 0;
  localparam int EN_CMD_ON = 2;
  localparam int EN_OCMD_W = 4;
  localparam int EN_OCMD_ON = 6;
  localparam int EN_ADDR_W = 8;
  localparam int EN_ADDR_SEL = 12;
  localparam int EN_OPT_W = 16;
  localparam int EN_OPT_SEL = 20;
  localparam int EN_DATA_W = 24;
  localparam int EN_DUMMY_ON = 28;
  localparam int DDR_DATA = 0;
  localparam int DDR_OPT = 4;
  localparam int DDR_ADDR = 8;
  localparam int LVL_RD0 = 12;
  localparam int LVL_L2 = 8;
  localparam int LVL_L3 = 10;
  localparam int CTRL_START = 0;
  localparam int CTRL_READ = 1;
  localparam int CTRL_DATA_ON = 2;
  localparam int CTRL_BYTES = 4;
  // Encodings.
  localparam logic [1:0] WIDTH_EIGHT = 2'h3;
  localparam logic [3:0] ADDR_24    = 4'h7;
  localparam logic [3:0] ADDR_32    = 4'hf;
  localparam logic [3:0] ADDR_OCTAL = 4'h4;
  localparam logic [3:0] OPT_B3     = 4'h8;
  localparam logic [3:0] OPT_B32    = 4'hc;
  localparam logic [3:0] OPT_B321   = 4'he;
  localparam logic [3:0] OPT_ALL    = 4'hf;
  localparam logic [1:0] LVL_ZERO   = 2'h0;
  localparam logic [1:0] LVL_ONE    = 2'h1;
  localparam logic [1:0] LVL_PREV   = 2'h2;
  localparam logic [1:0] LVL_HIZ    = 2'h3;
  localparam logic [4:0] DUMMY_MIN  = 5'h02;
  localparam logic [4:0] DUMMY_MAX  = 5'h14;
  localparam logic [5:0] BITS_BYTE  = 6'h08;
  localparam logic [5:0] BITS_24    = 6'h18;
  localparam logic [5:0] BITS_32    = 6'h20;
  localparam logic [2:0] PH_NONE    = 3'h6;
  localparam logic [5:0] CTRL_MASK  = 6'h36;
  // Reset values.
  localparam logic [31:0] RST_ENABLE = 32'h0000_0004;
  localparam logic [4:0]  RST_DUMMY  = 5'h08;
  localparam logic [13:0] RST_LEVEL  = 14'h35ff;
  // Frame phases in the order they go out on the wire.
  typedef enum logic [2:0] {
    OMF_CMD, OMF_OCMD, OMF_ADDR, OMF_OPT, OMF_DUMMY, OMF_DATA,
    OMF_IDLE, OMF_END
  } omf_phase_t;
endpackage
`default_nettype wire

//--- verification/omf_flash_model.sv
// Purpose: Behavioural flash at the far end of the serial pins.
// Assumes: One-line replies on line 1, shifted after each falling edge.
// Notes:   Counters run from time zero; the bench compares deltas.
`timescale 1ns/1ps
`default_nettype none
module omf_flash_model (
  // Flash pins.
  input  wire logic        chip_select_n,
  input  wire logic        flash_clock,
  input  wire logic [7:0]  line_o,
  input  wire logic [7:0]  line_oe,
  output logic      [7:0]  line_i,
  // Observation.
  input  wire logic [7:0]  rd_byte,
  output logic      [63:0] cap,
  output int               bits,
  output int               edges,
  output logic      [3:0]  l23
);
  logic [63:0] tx;
  initial begin
    bits = 0;
    edges = 0;
  end
  // Rising edges sample; an eight-line unit lands as one byte.
  always @(posedge flash_clock) begin
    if (!chip_select_n) begin
      edges <= edges + 1;
      l23   <= {line_oe[3:2], line_o[3:2]};
      if (line_oe[7]) begin
        cap  <= {cap[55:0], line_o};
        bits <= bits + 8;
      end else if (line_oe[0]) begin
        cap  <= {cap[62:0], line_o[0]};
        bits <= bits + 1;
      end
    end
  end
  // The reply waits behind the eight command bits.
  always @(negedge flash_clock or posedge chip_select_n) begin
    if (chip_select_n) tx <= {8'h00, rd_byte, 48'h0};
    else tx <= tx << 1;
  end
  // Deselected, the lines never repeat stale data.
  assign line_i = chip_select_n ? ~cap[7:0] : {6'h0, tx[63], 1'b0};
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// Purpose: Self-checking bench for the manual frame composer.
// Assumes: Zero-wait APB slave; flash model on the far side.
// Notes:   DDR is seen through serial clock counts only.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin \
  bad_count++; $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
  logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, s;
  logic        cs_n, fclk, busy;
  logic [7:0]  paddr, li, lo, loe;
  logic [3:0]  l23;
  logic [31:0] pwdata, prdata, r;
  logic [63:0] cap;
  int          bits, edges, b0, e0, bad_count, comparisons;
  omf_manual_frame u_dut (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_select_n(cs_n), .flash_clock(fclk), .flash_data_line_i(li),
    .flash_data_line_o(lo), .flash_data_line_oe(loe), .busy(busy));
  omf_flash_model u_flash (.chip_select_n(cs_n), .flash_clock(fclk),
    .line_o(lo), .line_oe(loe), .line_i(li), .rd_byte(8'ha6), .cap(cap),
    .bits(bits), .edges(edges), .l23(l23));
  // One APB transfer; the request holds until pready is seen.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    s = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Start a frame and wait, off the edge, for busy to drop.
  task automatic frame(input logic [31:0] ctrl);
    b0 = bits;
    e0 = edges;
    apb(1'b1, omf_pkg::OFS_CTRL, ctrl);
    do @(negedge clock); while (busy !== 1'b0);
    repeat (2) @(negedge clock);
  endtask
  task automatic t_reset;
    `CHK({cs_n, loe}, 9'h100)
    apb(1'b0, omf_pkg::OFS_ENABLE, 32'h0);
    `CHK(r, omf_pkg::RST_ENABLE)
    apb(1'b0, omf_pkg::OFS_DUMMY, 32'h0);
    `CHK(r[4:0], omf_pkg::RST_DUMMY)
    apb(1'b0, omf_pkg::OFS_LEVEL, 32'h0);
    `CHK(r[13:0], omf_pkg::RST_LEVEL)
    apb(1'b0, 8'h3c, 32'h0);
    `CHK({s, r}, 33'h1_0000_0000)
  endtask
  task automatic t_cmd;
    apb(1'b1, omf_pkg::OFS_LEVEL, 32'h3470);
    apb(1'b1, omf_pkg::OFS_CMD, 32'h005a_009f);
    apb(1'b1, omf_pkg::OFS_ENABLE, 32'h0);
    frame(32'h1);
    `CHK(edges - e0, 0)
    apb(1'b1, omf_pkg::OFS_ENABLE, 32'h4);
    frame(32'h1);
    `CHK(cap[7:0], 8'h9f)
    `CHK(l23, 4'he)
    `CHK({loe[3:0], lo[3:0] & loe[3:0]}, 8'hb8)
    apb(1'b1, omf_pkg::OFS_ENABLE, 32'h7);
    frame(32'h1);
    `CHK(edges - e0, 1)
  endtask
  // Every phase but data at once, then wider address and option settings, DDR and data.
  task automatic t_multi;
    apb(1'b1, omf_pkg::OFS_ADDR, 32'h7712_3456);
    apb(1'b1, omf_pkg::OFS_OPT, 32'hc1b2_a390);
    apb(1'b1, omf_pkg::OFS_DUMMY, 32'h4);
    apb(1'b1, omf_pkg::OFS_ENABLE, 32'h10c0_7074);
    frame(32'h1);
    `CHK(cap[55:0], 56'h9f5a_1234_56c1_b2)
    `CHK(edges - e0, 53)
    apb(1'b1, omf_pkg::OFS_ENABLE, 32'h00f0_f004);
    frame(32'h1);
    `CHK(cap, 64'h7712_3456_c1b2_a390)
    apb(1'b1, omf_pkg::OFS_DDR, 32'h100);
    apb(1'b1, omf_pkg::OFS_ENABLE, 32'h7004);
    frame(32'h1);
    `CHK(edges - e0, 20)
    apb(1'b1, omf_pkg::OFS_DDR, 32'h10);
    apb(1'b1, omf_pkg::OFS_ENABLE, 32'h00c0_0004);
    frame(32'h1);
    `CHK(edges - e0, 16)
    apb(1'b1, omf_pkg::OFS_DDR, 32'h1);
    apb(1'b1, omf_pkg::OFS_ENABLE, 32'h4);
    apb(1'b1, omf_pkg::OFS_WDATA, 32'h5a5a_c3e1);
    frame(32'h15);
    `CHK(edges - e0, 16)
    apb(1'b1, omf_pkg::OFS_DDR, 32'h0);
    apb(1'b1, omf_pkg::OFS_ENABLE, 32'h0);
    frame(32'h15);
    `CHK(cap[15:0], 16'hc3e1)
    `CHK(edges - e0, 16)
  endtask
  task automatic t_read;
    apb(1'b1, omf_pkg::OFS_ENABLE, 32'h4);
    frame(32'h7);
    `CHK(bits - b0, 8)
    apb(1'b0, omf_pkg::OFS_RDATA, 32'h0);
    `CHK(r, 32'h0000_00a6)
    apb(1'b1, omf_pkg::OFS_LEVEL, 32'h0570);
    frame(32'h7);
    `CHK(bits - b0, 16)
    `CHK(cap[7:0], 8'h00)
    `CHK(l23, 4'hf)
  endtask
  task automatic results;
    if (bad_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    t_reset;
    t_cmd;
    t_multi;
    t_read;
    results;
  end
  // A hang ends the run through the same closing task.
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    results;
  end
endmodule
`default_nettype wire
